// [common/tdp_pkg.sv]
// constants and types shared by the dual timer compare/pwm block
package tdp_pkg;

	// bus widths
	localparam int AW = 8;
	localparam int DW = 16;

	// global register word indices
	localparam logic [7:0] OFS_START = 8'h00;
	localparam logic [7:0] OFS_MODE  = 8'h01;

	// per channel block: address [7:4] = channel + 1, [3:0] = offset
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_CNT  = 4'h1;
	localparam logic [3:0] OFS_GRA  = 4'h2;
	localparam logic [3:0] OFS_GRB  = 4'h3;
	localparam logic [3:0] OFS_GRC  = 4'h4;
	localparam logic [3:0] OFS_GRD  = 4'h5;
	localparam logic [3:0] OFS_IO   = 4'h6;
	localparam logic [3:0] OFS_OE   = 4'h7;
	localparam logic [3:0] OFS_STAT = 4'h8;
	localparam logic [3:0] OFS_TRG  = 4'h9;

	// shared_start_register fields
	localparam int START_RUN_LSB  = 0;
	localparam int START_STOP_SELECT_BIT_LSB = 2;
	// mode_control_register fields
	localparam int MODE_SYNC = 0;
	// channel control fields
	localparam int CTRL_CKS_LSB  = 0;
	localparam int CTRL_EDGE_LSB = 3;
	localparam int CTRL_COUNTER_CLEAR_FIELD_LSB = 5;
	localparam int CTRL_PWM      = 7;
	localparam int CTRL_BUF      = 8;
	localparam int CTRL_ROUTE    = 9;
	localparam int CTRL_CUT      = 10;
	// output config fields
	localparam int OE_EN_LSB   = 0;
	localparam int OE_INIT_LSB = 4;
	localparam int OE_ACT_LSB  = 8;
	// status fields, bits 3:0 are matches a..d
	localparam int STAT_OVF = 4;

	// count source select codes
	localparam logic [2:0] CKS_HOCO = 3'h0;
	localparam logic [2:0] CKS_CLK  = 3'h1;
	localparam logic [2:0] CKS_DIV2 = 3'h2;
	localparam logic [2:0] CKS_DIV4 = 3'h3;
	localparam logic [2:0] CKS_DIV8 = 3'h4;
	localparam logic [2:0] CKS_DIV32 = 3'h5;
	localparam logic [2:0] CKS_EXT  = 3'h6;

	// external edge select
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;

	// counter_clear_field codes
	localparam logic [1:0] COUNTER_CLEAR_FIELD_FREE = 2'h0;
	localparam logic [1:0] COUNTER_CLEAR_FIELD_GRA  = 2'h1;
	localparam logic [1:0] COUNTER_CLEAR_FIELD_GRB  = 2'h2;

	// compare match pin actions
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW  = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOG  = 2'h3;

	// reset value of every register and counter, and the top of the count
	localparam logic [15:0] RST_REG = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;

	// per channel run state
	typedef enum logic {
		RUN_IDLE   = 1'b0,
		RUN_ACTIVE = 1'b1
	} tdp_run_e;

endpackage

// [design/tdp_timer.sv]
// two channel 16-bit compare / pwm timer with register port
`timescale 1ns/1ps

module tdp_timer (
	// clock and reset
	input  wire logic                   mclk_i,
	input  wire logic                   reset_i,
	// register port
	input  wire logic [tdp_pkg::AW-1:0] reg_addr_i,
	input  wire logic [tdp_pkg::DW-1:0] reg_wdata_i,
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	output logic      [tdp_pkg::DW-1:0] reg_rdata_o,
	// count sources
	input  wire logic                   hs_osc_tick_i,
	// timer pins, index ch*4 + {a,b,c,d}
	input  wire logic [7:0]             pin_i,
	output logic      [7:0]             pin_o,
	output logic      [7:0]             pin_oe_o,
	// cutoff and events
	input  wire logic                   cutoff_i,
	output logic      [1:0]             irq_o,
	output logic      [1:0]             adc_evt_o
);
	import tdp_pkg::*;

	typedef struct packed {
		tdp_run_e [1:0]       run;
		logic [1:0]           stop_select_bit;
		logic                 sync;
		logic [1:0][15:0]     ctrl;
		logic [1:0][15:0]     cnt;
		logic [1:0][3:0][15:0] gr;
		logic [1:0][15:0]     io;
		logic [1:0][15:0]     oe;
		logic [1:0][15:0]     stat;
		logic [1:0][15:0]     trg;
		logic [4:0]           pre;
		logic                 ext_q;
		logic [7:0]           pin;
		logic [7:0]           pin_oe;
		logic [15:0]          rdata;
		logic [1:0]           irq;
		logic [1:0]           evt;
	} tdp_state_s;

	tdp_state_s s_r;
	tdp_state_s s_nxt;

	// channel register hit
	function automatic logic hit(input logic [7:0] a, input int ch,
		input logic [3:0] off);
		return a[7:4] == 4'(ch + 1) && a[3:0] == off;
	endfunction

	// one-cycle count enable from the selected source
	function automatic logic src_tick(input logic [2:0] cks,
		input logic [1:0] edg, input logic [4:0] pre, input logic hs,
		input logic rise, input logic fall);
		logic t;
		t = 1'b0;
		unique case (cks)
			CKS_HOCO:  t = hs;
			CKS_CLK:   t = 1'b1;
			CKS_DIV2:  t = pre[0];
			CKS_DIV4:  t = &pre[1:0];
			CKS_DIV8:  t = &pre[2:0];
			CKS_DIV32: t = &pre;
			CKS_EXT: begin
				if (edg == EDGE_RISE)
					t = rise;
				else if (edg == EDGE_FALL)
					t = fall;
				else
					t = rise | fall;
			end
			default:   t = 1'b0;
		endcase
		return t;
	endfunction

	always_comb begin
		logic        rise;
		logic        fall;
		logic        tick;
		logic        pwm;
		logic        clr;
		logic        ovf;
		logic        ext_any;
		logic [1:0]  counter_clear_field;
		logic [1:0]  op;
		logic [3:0]  cm;
		logic [3:0]  act;
		logic [3:0]  mask;
		int          tgt;
		rise = 1'b0;
		fall = 1'b0;
		tick = 1'b0;
		pwm = 1'b0;
		clr = 1'b0;
		ovf = 1'b0;
		ext_any = 1'b0;
		counter_clear_field = COUNTER_CLEAR_FIELD_FREE;
		op = ACT_NONE;
		cm = '0;
		act = '0;
		mask = '0;
		tgt = 0;
		s_nxt = s_r;
		s_nxt.irq = '0;
		s_nxt.evt = '0;
		s_nxt.rdata = RST_REG;
		// shared prescaler: taps give /2 /4 /8 /32 enables
		s_nxt.pre = 5'(s_r.pre + 5'h01);
		// external clock edge on channel 0 pin a
		s_nxt.ext_q = pin_i[0];
		rise = pin_i[0] & ~s_r.ext_q;
		fall = ~pin_i[0] & s_r.ext_q;

		for (int ch = 0; ch < 2; ch++) begin
			pwm = s_r.ctrl[ch][CTRL_PWM];
			counter_clear_field = s_r.ctrl[ch][CTRL_COUNTER_CLEAR_FIELD_LSB +: 2];
			tick = src_tick(s_r.ctrl[ch][CTRL_CKS_LSB +: 3],
				s_r.ctrl[ch][CTRL_EDGE_LSB +: 2], s_r.pre,
				hs_osc_tick_i, rise, fall);
			if (s_r.ctrl[ch][CTRL_CKS_LSB +: 3] == CKS_EXT)
				ext_any = 1'b1;
			for (int k = 0; k < 4; k++) begin
				cm[k] = tick && s_r.run[ch] == RUN_ACTIVE
					&& s_r.cnt[ch] == s_r.gr[ch][k];
			end
			// buffered c/d only feed a/b, they never compare
			if (s_r.ctrl[ch][CTRL_BUF])
				cm[3:2] = 2'b00;
			// pwm always clears on the period register
			clr = (cm[0] && (pwm || counter_clear_field == COUNTER_CLEAR_FIELD_GRA))
				|| (cm[1] && !pwm && counter_clear_field == COUNTER_CLEAR_FIELD_GRB);
			ovf = tick && s_r.run[ch] == RUN_ACTIVE
				&& s_r.cnt[ch] == CNT_MAX && !clr;
			if (tick && s_r.run[ch] == RUN_ACTIVE) begin
				if (clr)
					s_nxt.cnt[ch] = RST_REG;
				else
					s_nxt.cnt[ch] = 16'(s_r.cnt[ch] + 16'h0001);
			end
			// self stop on period match, pins keep what the match made
			if (cm[0] && !s_r.stop_select_bit[ch])
				s_nxt.run[ch] = RUN_IDLE;
			if (cm[0] && s_r.ctrl[ch][CTRL_BUF]) begin
				s_nxt.gr[ch][0] = s_r.gr[ch][2];
				s_nxt.gr[ch][1] = s_r.gr[ch][3];
			end
			// pins only move on matches and on output config writes, so a stop freezes them
			act = s_r.oe[ch][OE_ACT_LSB +: 4];
			if (pwm) begin
				for (int k = 1; k < 4; k++) begin
					if (cm[k])
						s_nxt.pin[ch*4+k] = act[k];
				end
				// period end wins so n >= m gives no active phase
				for (int k = 1; k < 4; k++) begin
					if (cm[0])
						s_nxt.pin[ch*4+k] = ~act[k];
				end
			end else begin
				for (int k = 0; k < 4; k++) begin
					tgt = (s_r.ctrl[ch][CTRL_ROUTE] && k >= 2)
						? k - 2 : k;
					op = s_r.io[ch][k*2 +: 2];
					if (cm[k]) begin
						unique case (op)
							ACT_NONE: ;
							ACT_LOW:  s_nxt.pin[ch*4+tgt] = 1'b0;
							ACT_HIGH: s_nxt.pin[ch*4+tgt] = 1'b1;
							ACT_TOG:  s_nxt.pin[ch*4+tgt] =
								~s_r.pin[ch*4+tgt];
						endcase
					end
				end
			end
			// per pin output enable; cleared bits leave the pin a port
			mask = s_r.oe[ch][OE_EN_LSB +: 4];
			if (pwm)
				mask[0] = 1'b0;
			if (!pwm && s_r.ctrl[ch][CTRL_ROUTE])
				mask[3:2] = 2'b00;
			if (pwm && s_r.ctrl[ch][CTRL_CUT] && cutoff_i)
				mask = 4'h0;
			s_nxt.pin_oe[ch*4 +: 4] = mask;
			s_nxt.stat[ch] = s_r.stat[ch];
			s_nxt.irq[ch] = (|cm) | ovf;
			s_nxt.evt[ch] = |(cm & s_r.trg[ch][3:0]);
		end
		if (ext_any)
			s_nxt.pin_oe[0] = 1'b0;

		// register writes
		if (reg_wr_i) begin
			if (reg_addr_i == OFS_START) begin
				s_nxt.stop_select_bit = reg_wdata_i[START_STOP_SELECT_BIT_LSB +: 2];
				for (int ch = 0; ch < 2; ch++) begin
					if (reg_wdata_i[START_RUN_LSB + ch])
						s_nxt.run[ch] = RUN_ACTIVE;
					else if (reg_wdata_i[START_STOP_SELECT_BIT_LSB + ch])
						s_nxt.run[ch] = RUN_IDLE;
				end
			end
			if (reg_addr_i == OFS_MODE)
				s_nxt.sync = reg_wdata_i[MODE_SYNC];
			for (int ch = 0; ch < 2; ch++) begin
				if (hit(reg_addr_i, ch, OFS_CTRL))
					s_nxt.ctrl[ch] = reg_wdata_i;
				if (hit(reg_addr_i, ch, OFS_CNT)) begin
					if (s_r.sync) begin
						s_nxt.cnt[0] = reg_wdata_i;
						s_nxt.cnt[1] = reg_wdata_i;
					end else begin
						s_nxt.cnt[ch] = reg_wdata_i;
					end
				end
				for (int k = 0; k < 4; k++) begin
					if (hit(reg_addr_i, ch, 4'(OFS_GRA + k)))
						s_nxt.gr[ch][k] = reg_wdata_i;
				end
				if (hit(reg_addr_i, ch, OFS_IO))
					s_nxt.io[ch] = reg_wdata_i;
				if (hit(reg_addr_i, ch, OFS_OE)) begin
					s_nxt.oe[ch] = reg_wdata_i;
					s_nxt.pin[ch*4 +: 4] =
						reg_wdata_i[OE_INIT_LSB +: 4];
				end
				if (hit(reg_addr_i, ch, OFS_STAT))
					s_nxt.stat[ch] = s_r.stat[ch] & ~reg_wdata_i;
				if (hit(reg_addr_i, ch, OFS_TRG))
					s_nxt.trg[ch] = reg_wdata_i;
			end
		end
		// sticky flags: a hardware set beats a same-cycle clear
		for (int ch = 0; ch < 2; ch++) begin
			pwm = s_r.ctrl[ch][CTRL_PWM];
			tick = src_tick(s_r.ctrl[ch][CTRL_CKS_LSB +: 3],
				s_r.ctrl[ch][CTRL_EDGE_LSB +: 2], s_r.pre,
				hs_osc_tick_i, rise, fall);
			for (int k = 0; k < 4; k++) begin
				if (tick && s_r.run[ch] == RUN_ACTIVE
					&& s_r.cnt[ch] == s_r.gr[ch][k]
					&& !(k >= 2 && s_r.ctrl[ch][CTRL_BUF]))
					s_nxt.stat[ch][k] = 1'b1;
			end
			counter_clear_field = s_r.ctrl[ch][CTRL_COUNTER_CLEAR_FIELD_LSB +: 2];
			// a clearing match at the top is no wrap
			if (tick && s_r.run[ch] == RUN_ACTIVE
				&& s_r.cnt[ch] == CNT_MAX
				&& !((s_r.cnt[ch] == s_r.gr[ch][0]
				&& (pwm || counter_clear_field == COUNTER_CLEAR_FIELD_GRA))
				|| (s_r.cnt[ch] == s_r.gr[ch][1]
				&& !pwm && counter_clear_field == COUNTER_CLEAR_FIELD_GRB)))
				s_nxt.stat[ch][STAT_OVF] = 1'b1;
		end

		// register reads, data in the following cycle
		if (reg_rd_i) begin
			if (reg_addr_i == OFS_START) begin
				s_nxt.rdata[START_RUN_LSB +: 2] = s_r.run;
				s_nxt.rdata[START_STOP_SELECT_BIT_LSB +: 2] = s_r.stop_select_bit;
			end
			if (reg_addr_i == OFS_MODE)
				s_nxt.rdata[MODE_SYNC] = s_r.sync;
			for (int ch = 0; ch < 2; ch++) begin
				if (hit(reg_addr_i, ch, OFS_CTRL))
					s_nxt.rdata = s_r.ctrl[ch];
				if (hit(reg_addr_i, ch, OFS_CNT))
					s_nxt.rdata = s_r.cnt[ch];
				for (int k = 0; k < 4; k++) begin
					if (hit(reg_addr_i, ch, 4'(OFS_GRA + k)))
						s_nxt.rdata = s_r.gr[ch][k];
				end
				if (hit(reg_addr_i, ch, OFS_IO))
					s_nxt.rdata = s_r.io[ch];
				if (hit(reg_addr_i, ch, OFS_OE))
					s_nxt.rdata = s_r.oe[ch];
				if (hit(reg_addr_i, ch, OFS_STAT))
					s_nxt.rdata = s_r.stat[ch];
				if (hit(reg_addr_i, ch, OFS_TRG))
					s_nxt.rdata = s_r.trg[ch];
			end
		end
	end

	// all registers and counters clear to zero
	always_ff @(posedge mclk_i) begin
		if (reset_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign reg_rdata_o = s_r.rdata;
	assign pin_o       = s_r.pin;
	assign pin_oe_o    = s_r.pin_oe;
	assign irq_o       = s_r.irq;
	assign adc_evt_o   = s_r.evt;

endmodule

// [dv/tdp_timer_properties.sv]
// port assertions for the dual timer
`timescale 1ns/1ps
module tdp_timer_properties
	import tdp_pkg::*;
(
	// clock and reset
	input wire logic        mclk_i,
	input wire logic        reset_i,
	// register port
	input wire logic [7:0]  reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	// pins and events
	input wire logic        hs_osc_tick_i,
	input wire logic [7:0]  pin_i,
	input wire logic [7:0]  pin_o,
	input wire logic [7:0]  pin_oe_o,
	input wire logic        cutoff_i,
	input wire logic [1:0]  irq_o,
	input wire logic [1:0]  adc_evt_o
);
	logic [1:0] stop_r;
	logic       arm_r;
	logic       pwm_r;
	logic       ext_r;
	wire        oe1_wr = reg_wr_i && reg_addr_i == 8'h27;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	// shadows of control writes; self stop is not tracked, so stays lax
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			stop_r <= 2'h0;
			arm_r  <= 1'b0;
			pwm_r  <= 1'b0;
			ext_r  <= 1'b0;
		end else if (reg_wr_i) begin
			if (reg_addr_i == 8'h00)
				stop_r <= ~reg_wdata_i[1:0] & (reg_wdata_i[3:2] | stop_r);
			if (reg_addr_i == 8'h20) begin
				arm_r <= reg_wdata_i[CTRL_PWM] & reg_wdata_i[CTRL_CUT];
				pwm_r <= reg_wdata_i[CTRL_PWM];
			end
			if (reg_addr_i == 8'h10)
				ext_r <= reg_wdata_i[2:0] == CKS_EXT;
		end
	end
	chk_rdata_idle: assert property (
		!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
		else $error("read data outside its slot");
	chk_unmapped_zero: assert property (
		reg_rd_i && reg_addr_i[7:4] > 4'h2 |=> reg_rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	chk_cut_oe: assert property (
		cutoff_i && arm_r |=> pin_oe_o[7:4] == 4'h0)
		else $error("cutoff left outputs enabled");
	chk_pin_a1_port: assert property (
		pwm_r && $past(pwm_r) |-> !pin_oe_o[4])
		else $error("channel 1 pin a driven in pwm");
	chk_evt_irq: assert property (
		|adc_evt_o |-> (adc_evt_o & ~irq_o) == 2'h0)
		else $error("event without match request");
	chk_pins_hold: assert property (
		stop_r[1] && $past(stop_r[1]) && !$past(oe1_wr) &&
		!$past(oe1_wr, 2) |-> $stable(pin_o[7:4]))
		else $error("stopped channel moved its pins");
	chk_stop_quiet: assert property (
		stop_r[1] && $past(stop_r[1]) |-> irq_o[1] == 1'b0)
		else $error("stopped channel requested");
	chk_ext_pin_in: assert property (
		ext_r && $past(ext_r) |-> !pin_oe_o[0])
		else $error("count clock pin driven");
	cov_irq: cover property (irq_o[1]);
	cov_cut: cover property (cutoff_i && arm_r);
	cov_stop: cover property (stop_r[1] && pwm_r);
endmodule
bind tdp_timer tdp_timer_properties tdp_timer_properties_i (
	.mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .hs_osc_tick_i(hs_osc_tick_i),
	.pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
	.cutoff_i(cutoff_i), .irq_o(irq_o), .adc_evt_o(adc_evt_o));

// [dv/tdp_load.sv]
// external loads on the timer pins and a free count clock
`timescale 1ns/1ps
module tdp_load (
	// clock
	input  wire logic       mclk_i,
	// timer side
	input  wire logic [7:0] drv_i,
	input  wire logic [7:0] en_i,
	output logic      [7:0] lvl_o
);
	logic [1:0] div_r = 2'h0;
	always_ff @(posedge mclk_i)
		div_r <= div_r + 2'h1;
	// pull-downs, so a released pin reads low, except pin 0, which carries the free count clock
	always_comb begin
		lvl_o = drv_i & en_i;
		if (!en_i[0])
			lvl_o[0] = div_r[1];
	end
endmodule

// [dv/testbench.sv]
// self-checking bench for the dual timer
`timescale 1ns/1ps
module testbench;
	import tdp_pkg::*;
	logic        mclk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic        hs_osc_tick_i = 1'b0;
	logic        cutoff_i = 1'b0;
	logic [1:0]  hs_r = 2'h0;
	logic [15:0] reg_rdata_o, v;
	logic [7:0]  pin_i, pin_o, pin_oe_o;
	logic [1:0]  irq_o, adc_evt_o;
	logic        lvl;
	int          n_fail = 0;
	int          num_checks = 0;
	int          hi, lo, e;
	int          dv[7] = '{4, 1, 2, 4, 8, 32, 4};
	tdp_timer tdp_timer_i (.mclk_i(mclk_i), .reset_i(reset_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.hs_osc_tick_i(hs_osc_tick_i), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe_o(pin_oe_o), .cutoff_i(cutoff_i), .irq_o(irq_o),
		.adc_evt_o(adc_evt_o));
	tdp_load tdp_load_i (.mclk_i(mclk_i), .drv_i(pin_o), .en_i(pin_oe_o),
		.lvl_o(pin_i));
	initial forever #4 mclk_i = ~mclk_i;
	// oscillator tick every fourth cycle
	always @(posedge mclk_i) begin
		hs_r <= hs_r + 2'h1;
		hs_osc_tick_i <= hs_r == 2'h3;
	end
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task check(input string nm, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask
	// cycles that channel 1 pin b stays at one level, bounded
	task meas(input logic l, output int n);
		n = 0;
		while (pin_o[5] === l) begin
			@(posedge mclk_i);
			#1 n++;
			if (n > 200) begin
				n_fail++;
				summarize;
			end
		end
	endtask
	initial begin
		repeat (16) @(posedge mclk_i);
		reset_i <= 1'b0;
		rd(8'h00, v); check("start", v, RST_REG);
		rd(8'h11, v); check("cnt0", v, RST_REG);
		rd(8'hf3, v); check("hole", v, 16'h0000);
		// each count source over a 66 cycle window
		for (int c = 0; c < 7; c++) begin
			wr(8'h10, 16'(c));
			wr(8'h11, 16'h0000);
			wr(8'h00, 16'h0005);
			repeat (64) @(posedge mclk_i);
			wr(8'h00, 16'h0004);
			rd(8'h11, v);
			e = 66 / dv[c];
			check("rate", 16'(v >= e - 2 && v <= e + 2), 16'h0001);
		end
		// compare output, clear and stop at match a
		wr(8'h29, 16'h000f);
		wr(8'h26, {14'h0, ACT_HIGH});
		wr(8'h27, 16'h0001);
		wr(8'h22, 16'h0014);
		wr(8'h20, 16'h0021);
		wr(8'h00, 16'h0002);
		repeat (40) @(posedge mclk_i);
		rd(8'h21, v); check("clr", v, 16'h0000);
		rd(8'h00, v); check("self_stop", v, 16'h0000);
		check("pin", {14'h0, pin_oe_o[4], pin_o[4]}, 16'h0003);
		// wrap from the top of the count
		wr(8'h20, 16'h0001);
		wr(8'h21, 16'hfffe);
		wr(8'h28, 16'h001f);
		wr(8'h00, 16'h0002);
		repeat (6) @(posedge mclk_i);
		rd(8'h28, v); check("ovf", {15'h0, v[STAT_OVF]}, 16'h0001);
		rd(8'h21, v); check("wrap", 16'(v < 16'h0014), 16'h0001);
		repeat (30) @(posedge mclk_i);
		// a running channel would step past the loaded value
		wr(8'h00, 16'h0008);
		wr(8'h01, 16'h0001);
		wr(8'h11, 16'h1234);
		rd(8'h21, v); check("sync", v, 16'h1234);
		wr(8'h01, 16'h0000);
		wr(8'h11, 16'h0055);
		rd(8'h21, v); check("nosync", v, 16'h1234);
		// pwm on pin b, period 10, active 6
		wr(8'h22, 16'h0009);
		wr(8'h23, 16'h0003);
		wr(8'h27, 16'h0203);
		wr(8'h20, 16'h0481);
		wr(8'h21, 16'h0000);
		wr(8'h00, 16'h000a);
		meas(1'b0, hi);
		meas(1'b1, hi);
		meas(1'b0, lo);
		meas(1'b1, hi);
		check("high", 16'(hi), 16'h0006);
		check("period", 16'(hi + lo), 16'h000a);
		check("a1_port", {15'h0, pin_oe_o[4]}, 16'h0000);
		wr(8'h00, 16'h0008);
		repeat (2) @(posedge mclk_i);
		#1 lvl = pin_o[5];
		repeat (20) @(posedge mclk_i);
		#1 check("hold", {15'h0, pin_o[5]}, {15'h0, lvl});
		@(posedge mclk_i);
		cutoff_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		#1 check("cut", {12'h0, pin_oe_o[7:4]}, 16'h0000);
		summarize;
	end
endmodule
